// [src/alu_flags_consts.svh]
`ifndef ALU_FLAGS_CONSTS_SVH
`define ALU_FLAGS_CONSTS_SVH
// ----------------------------------------
// register map and field layout
// ----------------------------------------
`define FLAG_REG_ADDR     12'hfd8
`define FLAG_REG_RESET    8'h00
`define FLAG_BIT_NEG      4
`define FLAG_BIT_WRAP     3
`define FLAG_BIT_ZERO     2
`define FLAG_BIT_NIBBLE   1
`define FLAG_BIT_CARRY    0
`define FLAG_IMPL_MASK    8'h1f
`endif

// [src/alu_flags_pkg.sv]
package alu_flags_pkg;
   // ----------------------------------------
   // operation codes from the execution unit
   // ----------------------------------------
   typedef enum logic [3:0] {
      op_none            = 4'h0,
      add_w_to_file      = 4'h1,
      add_literal_to_w   = 4'h2,
      sub_w_from_literal = 4'h3,
      sub_w_from_file    = 4'h4,
      clear_file_op      = 4'h5,
      bit_clear_op       = 4'h6,
      bit_set_op         = 4'h7,
      nibble_swap_op     = 4'h8,
      file_to_file_move  = 4'h9,
      w_to_file_move     = 4'ha,
      rotate_right_op    = 4'hb,
      rotate_left_op     = 4'hc,
      logic_and_op       = 4'hd,
      logic_or_op        = 4'he,
      logic_xor_op       = 4'hf
   } alu_op_t;

   // one execute request
   typedef struct packed {
      logic        valid;
      alu_op_t     op;
      logic [7:0]  a;      // file or literal operand
      logic [7:0]  w;      // working register
      logic [11:0] dest;   // destination address
      logic        dest_f; // result goes to file, not w
      logic        carry_in;
   } exec_req_t;

   // flag outcome of one operation
   typedef struct packed {
      logic [7:0] result;
      logic [4:0] flags;   // neg, wrap, zero, nibble, carry
      logic [4:0] touch;   // which flags the op updates
   } flag_res_t;
endpackage : alu_flags_pkg

// [src/alu_flag_calc.sv]
`timescale 1ns/1ps
`include "alu_flags_consts.svh"
module alu_flag_calc (
   // operation in
   input  alu_flags_pkg::exec_req_t req_i,
   // result and flags out
   output alu_flags_pkg::flag_res_t res_o
);
   import alu_flags_pkg::*;

   logic [8:0] sum;
   logic [4:0] low;
   logic [7:0] x;
   logic [7:0] y;
   logic [7:0] r;

   // subtract as add of the inverted operand plus one
   always_comb begin
      x = req_i.a;
      y = req_i.w;
      unique case (req_i.op)
         sub_w_from_literal, sub_w_from_file: begin
            y = ~req_i.w;
         end
         default: begin
            y = req_i.w;
         end
      endcase
   end

   // carry-in of one only for subtraction
   always_comb begin
      logic cin;
      cin = (req_i.op == sub_w_from_literal) || (req_i.op == sub_w_from_file);
      sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
   end

   // result and per-op flag updates
   always_comb begin
      r           = 8'h00;
      res_o.flags = 5'h00;
      res_o.touch = 5'h00;
      unique case (req_i.op)
         add_w_to_file, add_literal_to_w, sub_w_from_literal, sub_w_from_file: begin
            r           = sum[7:0];
            res_o.touch = 5'h1f;
            res_o.flags[`FLAG_BIT_CARRY]  = sum[8];
            res_o.flags[`FLAG_BIT_NIBBLE] = low[4];
            // sign flips when both inputs share a sign the result lacks
            res_o.flags[`FLAG_BIT_WRAP]   = (x[7] == y[7]) && (sum[7] != x[7]);
         end
         clear_file_op: begin
            r           = 8'h00;
            res_o.touch = 5'h04;
         end
         logic_and_op, logic_or_op, logic_xor_op: begin
            r = (req_i.op == logic_and_op) ? (req_i.a & req_i.w) :
                (req_i.op == logic_or_op)  ? (req_i.a | req_i.w) : (req_i.a ^ req_i.w);
            res_o.touch = 5'h14;
         end
         rotate_right_op: begin
            r           = {req_i.carry_in, req_i.a[7:1]};
            res_o.touch = 5'h17;
            res_o.flags[`FLAG_BIT_CARRY]  = req_i.a[0];
            res_o.flags[`FLAG_BIT_NIBBLE] = req_i.a[4];
         end
         rotate_left_op: begin
            r           = {req_i.a[6:0], req_i.carry_in};
            res_o.touch = 5'h17;
            res_o.flags[`FLAG_BIT_CARRY]  = req_i.a[7];
            res_o.flags[`FLAG_BIT_NIBBLE] = req_i.a[3];
         end
         nibble_swap_op: begin
            r = {req_i.a[3:0], req_i.a[7:4]};
         end
         bit_clear_op: begin
            r = req_i.a & ~req_i.w; // w carries the bit mask
         end
         bit_set_op: begin
            r = req_i.a | req_i.w;
         end
         file_to_file_move: begin
            r = req_i.a;
         end
         w_to_file_move: begin
            r = req_i.w;
         end
         op_none: begin
            r = req_i.a;
         end
      endcase
      res_o.flags[`FLAG_BIT_NEG]  = r[7];
      res_o.flags[`FLAG_BIT_ZERO] = (r == 8'h00);
      if (!res_o.touch[`FLAG_BIT_NEG]) begin
         res_o.flags[`FLAG_BIT_NEG] = 1'b0;
      end
      if (!res_o.touch[`FLAG_BIT_ZERO]) begin
         res_o.flags[`FLAG_BIT_ZERO] = 1'b0;
      end
      res_o.result = r;
   end

endmodule : alu_flag_calc

// [src/alu_status_flags.sv]
`timescale 1ns/1ps
`include "alu_flags_consts.svh"
module alu_status_flags (
   // clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_b_i,
   // execute port
   input  wire alu_flags_pkg::exec_req_t exec_i,
   output      logic [7:0]               result_o,
   output      logic                     result_vld_o,
   // software register port
   input  wire logic [11:0]              reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output      logic [7:0]               reg_rdata_o,
   // flag view
   output      logic [7:0]               flags_o
);
   import alu_flags_pkg::*;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_s1_r;
   logic rst_b_r;

   // two stages so release never lands mid-edge
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_r <= 1'b0;
         rst_b_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_b_r  <= rst_s1_r;
      end
   end

   // ----------------------------------------
   // flag computation
   // ----------------------------------------
   flag_res_t  calc;
   exec_req_t  req;
   logic [4:0] flag_r;

   // carry in for rotates comes from the held flag
   always_comb begin
      req          = exec_i;
      req.carry_in = flag_r[`FLAG_BIT_CARRY];
   end

   alu_flag_calc u_calc (
      .req_i (req),
      .res_o (calc)
   );

   // ----------------------------------------
   // register update
   // ----------------------------------------
   logic       exec_hits;
   logic [4:0] flag_nxt;

   assign exec_hits = exec_i.valid && exec_i.dest_f && (exec_i.dest == `FLAG_REG_ADDR);

   // op flags first; a destination write lands only from flag-neutral ops
   always_comb begin
      flag_nxt = flag_r;
      if (exec_i.valid) begin
         flag_nxt = (flag_r & ~calc.touch) | (calc.flags & calc.touch);
         // an op that moves any flag shuts its own write out of all five bits
         if (exec_hits && (calc.touch == 5'h00)) begin
            flag_nxt = calc.result[4:0];
         end
      end else if (reg_wr_i && (reg_addr_i == `FLAG_REG_ADDR)) begin
         flag_nxt = reg_wdata_i[4:0];
      end
   end

   // flags commit at end of execute cycle
   always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
      if (!rst_b_r) begin
         flag_r <= 5'h00;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // ----------------------------------------
   // result and read data
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
      if (!rst_b_r) begin
         result_o     <= 8'h00;
         result_vld_o <= 1'b0;
      end else begin
         result_o     <= calc.result;
         result_vld_o <= exec_i.valid;
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge sys_clk_i or negedge rst_b_r) begin
      if (!rst_b_r) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i && (reg_addr_i == `FLAG_REG_ADDR)) begin
         reg_rdata_o <= {3'h0, flag_r};
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   assign flags_o = {3'h0, flag_r};
endmodule : alu_status_flags

// [testbench/alu_flags_assertions.sv]
`timescale 1ns/1ps
`include "alu_flags_consts.svh"
module alu_flags_assertions (
   // clock and reset
   input wire logic                     sys_clk_i,
   input wire logic                     rst_b_i,
   // execute port
   input wire alu_flags_pkg::exec_req_t exec_i,
   input wire logic [7:0]               result_o,
   input wire logic                     result_vld_o,
   // register port and flag view
   input wire logic [11:0]              reg_addr_i,
   input wire logic [7:0]               reg_wdata_i,
   input wire logic                     reg_wr_i,
   input wire logic                     reg_rd_i,
   input wire logic [7:0]               reg_rdata_o,
   input wire logic [7:0]               flags_o
);
   import alu_flags_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ----
   // reference adder: subtract adds inverted operand plus one
   // ----
   logic       go, st, sb;
   logic [3:0] op;
   logic [7:0] a, b;
   logic [8:0] s;
   logic [4:0] n;
   logic [2:0] sf;
   logic [1:0] rf;
   assign go = exec_i.valid;
   assign op = exec_i.op;
   assign a  = exec_i.a;
   assign st = exec_i.dest == `FLAG_REG_ADDR && exec_i.dest_f;
   assign sb = op == 4'h3 || op == 4'h4;
   assign b  = sb ? ~exec_i.w : exec_i.w;
   assign s  = a + b + sb;
   assign n  = a[3:0] + b[3:0] + sb;
   assign sf = {a[7] == b[7] && s[7] != a[7], n[4], s[8]};
   assign rf = op[0] ? {a[4], a[0]} : {a[3], a[7]};
   sequence s_arith; go && op inside {[1:4]}; endsequence
   sequence s_read; reg_rd_i && reg_addr_i == `FLAG_REG_ADDR && !go; endsequence
   a_upper_zero:
   assert property (flags_o[7:5] == 3'h0 && reg_rdata_o[7:5] == 3'h0) else $error("upper bits set");
   a_vld_follow:
   assert property (result_vld_o == $past(go)) else $error("result valid misplaced");
   a_sum_flags:
   assert property (s_arith |=> {flags_o[3], flags_o[1:0]} == $past(sf)) else $error("sum flags wrong");
   a_sum_result:
   assert property (s_arith |=> result_o == $past(s[7:0])) else $error("sum wrong");
   a_sign_zero:
   assert property (go && op inside {[1:4], [11:15]} |=> flags_o[4] == result_o[7]
      && flags_o[2] == (result_o == 8'h00)) else $error("sign or zero wrong");
   a_keep_flags:
   assert property (go && op inside {0, [6:10]} && !st |=> $stable(flags_o)) else $error("flags disturbed");
   a_clear_zero:
   assert property (go && op == 4'h5 && st |=> flags_o == ($past(flags_o) | 8'h04)) else $error("clear wrong");
   a_rotate_flags:
   assert property (go && op inside {[11:12]} |=> flags_o[1:0] == $past(rf) && $stable(flags_o[3]))
      else $error("rotate flags wrong");
   a_sw_write:
   assert property (reg_wr_i && reg_addr_i == `FLAG_REG_ADDR && !go |=>
      flags_o == {3'h0, $past(reg_wdata_i[4:0])}) else $error("write lost");
   a_sw_read:
   assert property (s_read |=> reg_rdata_o == flags_o) else $error("read wrong");
endmodule : alu_flags_assertions
bind alu_status_flags alu_flags_assertions u_chk (.sys_clk_i, .rst_b_i, .exec_i, .result_o, .result_vld_o,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flags_o);

// [testbench/exec_unit_model.sv]
`timescale 1ns/1ps
module exec_unit_model (
   // issue from bench
   input  wire logic                      sys_clk_i,
   input  wire logic                      go_i,
   input  wire logic [3:0]                op_i,
   input  wire logic [7:0]                a_i,
   input  wire logic [7:0]                w_i,
   input  wire logic [11:0]               dest_i,
   // request to flag logic
   output      alu_flags_pkg::exec_req_t  req_o
);
   import alu_flags_pkg::*;
   initial req_o = '0;
   // idle fields toggle so stale operands never look settled
   always @(posedge sys_clk_i) begin
      if (go_i) req_o <= '{1'b1, alu_op_t'(op_i), a_i, w_i, dest_i, 1'b1, 1'b0};
      else req_o <= {1'b0, ~req_o[33:0]};
   end
endmodule : exec_unit_model

// [testbench/alu_status_flags_tb_top.sv]
`timescale 1ns/1ps
`include "alu_flags_consts.svh"
module alu_status_flags_tb_top;
   import alu_flags_pkg::*;
   logic        clk = 0, rst_b = 0, go = 0, wr = 0, rd = 0, rd_d = 0, result_vld_o;
   logic [3:0]  m_op = 0;
   logic [7:0]  m_a = 0, m_w = 0, wd = 0, f = 0, result_o, flags_o, reg_rdata_o;
   logic [11:0] m_d = 0, ad = 0;
   logic [16:0] e;
   logic [16:0] eq[$];
   logic [7:0]  rq[$];
   int          bad_count = 0, checked = 0, cyc = 0;
   exec_req_t   req;
   initial forever #12.5 clk = ~clk;
   exec_unit_model u_exec (.sys_clk_i(clk), .go_i(go), .op_i(m_op), .a_i(m_a), .w_i(m_w), .dest_i(m_d), .req_o(req));
   alu_status_flags u_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .exec_i(req), .result_o, .result_vld_o,
      .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o, .flags_o);
   // ----
   // shared tasks
   // ----
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask : cmp
   task automatic complete_run();
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // one strobe cycle; for a read d is the expected data
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      ad <= a;
      wd <= d;
      if (!w) rq.push_back(d);
      @(posedge clk);
      wr <= 0;
      rd <= 0;
   endtask : bus
   task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] w, input logic st);
      logic [8:0] s;
      logic [4:0] n;
      logic [7:0] b, r;
      logic       sb;
      sb = op == 4'h3 || op == 4'h4;
      b = sb ? ~w : w;
      s = a + b + sb;
      n = a[3:0] + b[3:0] + sb;
      r = s[7:0];
      case (op)
         4'h0: r = a;
         4'h5: begin
            r    = 8'h00;
            f[2] = 1'b1;
         end
         4'h6: r = a & ~w;
         4'h7: r = a | w;
         4'h8: r = {a[3:0], a[7:4]};
         4'h9: r = a;
         4'ha: r = w;
         4'hb: r = {f[0], a[7:1]};
         4'hc: r = {a[6:0], f[0]};
         4'hd: r = a & w;
         4'he: r = a | w;
         4'hf: r = a ^ w;
         default: f[3:0] = {a[7] == b[7] && r[7] != a[7], r == 8'h00, n[4], s[8]};
      endcase
      if ((op != 4'h0 && op < 4'h5) || op > 4'ha) f[4] = r[7];
      if (op > 4'ha) f[2] = r == 8'h00;
      if (op == 4'hb || op == 4'hc) f[1:0] = op[0] ? {a[4], a[0]} : {a[3], a[7]};
      if (st && (op == 4'h0 || (op > 4'h5 && op < 4'hb))) f = {3'h0, r[4:0]};
      eq.push_back({op < 4'h5, r, f});
      go <= 1;
      m_op <= op;
      m_a <= a;
      m_w <= w;
      m_d <= st ? `FLAG_REG_ADDR : 12'h010;
   endtask : issue
   // watcher: results and read data against oldest notes
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rd_d <= rd;
      if (result_vld_o === 1'b1) begin
         e = eq.pop_front();
         cmp({result_o, flags_o}, e[15:0]);
      end
      if (rd_d) cmp({8'h00, reg_rdata_o}, {8'h00, rq.pop_front()});
      if (cyc == 2000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      logic [3:0] op;
      logic [7:0] a;
      logic       st;
      void'($urandom(32'h846432c3));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      bus(0, `FLAG_REG_ADDR, 8'h00);
      bus(0, 12'h123, 8'h00);
      bus(1, `FLAG_REG_ADDR, 8'hff);
      bus(1, 12'h123, 8'h00);
      f = 8'h1f;
      bus(0, `FLAG_REG_ADDR, f);
      // every op code; a write lands beside each execute and must lose
      for (int i = 0; i < 64; i++) begin
         op = 4'(i % 16);
         st = 1'($urandom_range(1, 0));
         a = (st && (op == 4'h0 || (op > 4'h5 && op < 4'hb))) ? f : 8'($urandom);
         @(posedge clk);
         issue(op, a, 8'($urandom), st);
         @(posedge clk);
         go <= 0;
         wr <= 1;
         ad <= `FLAG_REG_ADDR;
         wd <= 8'($urandom);
         bus(0, `FLAG_REG_ADDR, f);
      end
      repeat (4) @(posedge clk);
      complete_run();
   end
endmodule : alu_status_flags_tb_top
